// *** pkg/lsc_pkg.sv ***
// Constants, types and helper functions shared by the serial channel files.
package lsc_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] LSC_CTRL_OFS = 8'h00;
  localparam logic [7:0] LSC_STAT_OFS = 8'h04;
  localparam logic [7:0] LSC_CMD_OFS = 8'h08;

  // Control fields.
  localparam int LSC_FACTOR_LSB = 0;
  localparam int LSC_MODE_LSB = 4;
  localparam int LSC_BYP_LSB = 6;
  localparam int LSC_SLIP_BIT = 8;
  localparam int LSC_HOLD_BIT = 9;
  localparam logic [9:0] LSC_CTRL_RST = 10'h01A;

  // Command fields, self clearing.
  localparam int LSC_DPA_RST_BIT = 0;
  localparam int LSC_FIFO_RST_BIT = 1;

  // Status fields.
  localparam int LSC_LOCKED_BIT = 0;
  localparam int LSC_PRIMED_BIT = 1;
  localparam int LSC_VALID_BIT = 2;
  localparam int LSC_PHASE_LSB = 4;
  localparam int LSC_SLIPCNT_LSB = 8;

  // ****************************************
  // Sizes and counts
  // ****************************************
  localparam int LSC_MAX_FACTOR = 10;
  localparam int LSC_PHASES = 8;
  localparam int LSC_FIFO_DEPTH = 6;
  localparam logic [3:0] LSC_MIN_FACTOR = 4'h3;
  localparam logic [3:0] LSC_TOP_FACTOR = 4'hA;
  localparam logic [2:0] LSC_LOCK_COUNT = 3'h4;
  localparam logic [2:0] LSC_SLIP_SETTLE = 3'h4;
  localparam logic [2:0] LSC_FIFO_PRIME = 3'h3;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    LSC_NON_DPA = 2'b00,
    LSC_DPA = 2'b01,
    LSC_SOFT_CDR = 2'b10
  } lsc_mode_t;

  typedef enum logic [1:0] {
    LSC_BYP_NONE = 2'b00,
    LSC_BYP_SDR = 2'b01,
    LSC_BYP_DDR = 2'b10
  } lsc_byp_t;

  // Word length on the wire for the current setup.
  function automatic logic [3:0] lsc_eff_factor(input logic [1:0] byp, input logic [3:0] factor);
    if (byp == LSC_BYP_SDR) begin
      return 4'h1;
    end else if (byp == LSC_BYP_DDR) begin
      return 4'h2;
    end
    return factor;
  endfunction

  // Low bits set for a word of the given length.
  function automatic logic [9:0] lsc_mask(input logic [3:0] len);
    return 10'(({11'h000, 1'b0} | 11'h001) << len) - 10'h001;
  endfunction

endpackage

// *** pkg/lsc_dpa_if.sv ***
// Signals between the channel and its phase selector.
`timescale 1ns/10ps
`default_nettype none
interface lsc_dpa_if;
  logic [7:0] samples;
  logic hold;
  logic rst;
  logic [2:0] phase;
  logic locked;
  logic first_lock;

  modport sel (
    input samples,
    input hold,
    input rst,
    output phase,
    output locked,
    output first_lock
  );

  modport user (
    output samples,
    output hold,
    output rst,
    input phase,
    input locked,
    input first_lock
  );
endinterface
`default_nettype wire

// *** rtl/lsc_phase_sel.sv ***
// Phase selector: picks the sample phase farthest from the data edges.
`timescale 1ns/10ps
`default_nettype none
module lsc_phase_sel
  import lsc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Channel side
  lsc_dpa_if.sel dpa
);

  typedef enum logic [1:0] {
    LSC_SEEK = 2'b00,
    LSC_TRACK = 2'b01
  } lsc_psel_state_t;

  // Returns {found, position} of the first data edge within one bit period.
  function automatic logic [3:0] edge_pos(input logic [7:0] s, input logic last);
    logic [3:0] r;
    r = {1'b0, 3'h0};
    if (s[0] != last) begin
      r = 4'h8;
    end else begin
      for (int i = 7; i >= 1; i--) begin
        if (s[i] != s[i - 1]) begin
          r = {1'b1, 3'(i)};
        end
      end
    end
    return r;
  endfunction

  lsc_psel_state_t state_reg;
  logic [2:0] cand_reg;
  logic [2:0] run_reg;
  logic [2:0] phase_reg;
  logic locked_reg;
  logic first_reg;
  logic last_reg;

  wire logic [3:0] edge_w = edge_pos(dpa.samples, last_reg);
  // R7 opposite the edge
  wire logic [2:0] best_w = edge_w[2:0] + 3'h4;
  wire logic same_w = edge_w[3] && (best_w == cand_reg);
  wire logic agreed_w = same_w && (run_reg == LSC_LOCK_COUNT - 3'h1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= LSC_SEEK;
      cand_reg <= 3'h0;
      run_reg <= 3'h0;
      phase_reg <= 3'h0;
      locked_reg <= 1'b0;
      first_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      last_reg <= dpa.samples[7];
      first_reg <= 1'b0;
      // R10 retrain after reset
      if (dpa.rst) begin
        state_reg <= LSC_SEEK;
        run_reg <= 3'h0;
        locked_reg <= 1'b0;
      end else if (edge_w[3]) begin
        cand_reg <= best_w;
        run_reg <= same_w ? (agreed_w ? run_reg : run_reg + 3'h1) : 3'h1;
        unique case (state_reg)
          // R9 lock on transitions
          LSC_SEEK: begin
            if (agreed_w) begin
              phase_reg <= cand_reg;
              locked_reg <= 1'b1;
              first_reg <= 1'b1;
              state_reg <= LSC_TRACK;
            end
          end
          // R8 keep tracking unless held
          LSC_TRACK: begin
            if (agreed_w && !dpa.hold) begin
              phase_reg <= cand_reg;
            end
          end
          default: state_reg <= LSC_SEEK;
        endcase
      end
    end
  end

  assign dpa.phase = phase_reg;
  assign dpa.locked = locked_reg;
  assign dpa.first_lock = first_reg;

endmodule
`default_nettype wire

// *** rtl/lsc_serdes_channel.sv ***
// One serial channel: serializer, phase-aligned deserializer and register slave.
`timescale 1ns/10ps
`default_nettype none

// What this block does
// R1 - Serializer takes 3 to 10 bit words
// R2 - Serial output sends word MSB first
// R3 - Bypass offers single or double rate output
// R4 - Bypass output register runs on channel clock
// R5 - Receive factor set statically, three to ten
// R6 - Shift and load registers deliver word
// R7 - Pick phase nearest data, eighth-bit error
// R8 - Keep tracking phase unless hold asserted
// R9 - Lock on transitions, flag initial lock
// R10 - Phase reset needs retraining before use
// R11 - Phase selector unused without alignment mode
// R12 - One-bit six-deep FIFO absorbs phase only
// R13 - FIFO cleared on first lock or request
// R14 - Fabric clears FIFO on corrupt data
// R15 - FIFO bypassed in non-aligned and recovery modes
// R16 - Slip edge inserts one bit latency
// R17 - Slip held one parallel cycle each level
// R18 - Realigned word valid four cycles later
// R19 - Slip count rolls at factor, pulses
// R20 - Deserializer bypass gives x1 or x2 capture
// R21 - Non-aligned mode samples on channel clock edge
// R22 - No alignment or slip in bypass
// R23 - Recovery mode forwards divided phase clock
// R24 - Load one word every factor cycles
// R25 - Received word stable whole parallel cycle
module lsc_serdes_channel
  import lsc_pkg::*;
#(
  parameter int MAX_FACTOR = LSC_MAX_FACTOR,
  parameter int PHASES = LSC_PHASES,
  parameter int FIFO_DEPTH = LSC_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Register bus
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Transmit side
  input wire logic [9:0] tx_word,
  output logic tx_take,
  output logic tx_serial,
  // Receive side
  input wire logic [7:0] rx_samples,
  output logic [9:0] rx_word,
  output logic rx_word_valid,
  output logic rx_locked,
  output logic rx_slip_max,
  output logic rx_divclk
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  if (MAX_FACTOR != 10 || PHASES != 8 || FIFO_DEPTH < 4 || FIFO_DEPTH > 8) begin : g_bad_param
    $error("Unsupported channel parameters.");
  end

  // ****************************************
  // Register bus slave
  // ****************************************
  logic [9:0] ctrl_reg;
  logic dpa_rst_reg;
  logic fifo_rst_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;

  wire logic setup_w = psel && !penable;
  wire logic sel_ctrl_w = (paddr == LSC_CTRL_OFS);
  wire logic sel_stat_w = (paddr == LSC_STAT_OFS);
  wire logic sel_cmd_w = (paddr == LSC_CMD_OFS);
  wire logic mapped_w = sel_ctrl_w || sel_stat_w || sel_cmd_w;
  wire logic wr_fire_w = psel && penable && pwrite && pready_reg && mapped_w;
  wire logic wr_ctrl_w = wr_fire_w && sel_ctrl_w;
  wire logic wr_cmd_w = wr_fire_w && sel_cmd_w;

  // R5 only legal factors are taken
  wire logic [3:0] wr_factor_w = pwdata[LSC_FACTOR_LSB +: 4];
  wire logic factor_ok_w = (wr_factor_w >= LSC_MIN_FACTOR) && (wr_factor_w <= LSC_TOP_FACTOR);
  wire logic [3:0] factor_new_w = factor_ok_w ? wr_factor_w : ctrl_reg[LSC_FACTOR_LSB +: 4];
  wire logic [1:0] mode_new_w = (pwdata[LSC_MODE_LSB +: 2] != 2'b11) ?
                                pwdata[LSC_MODE_LSB +: 2] : ctrl_reg[LSC_MODE_LSB +: 2];
  wire logic [1:0] byp_new_w = (pwdata[LSC_BYP_LSB +: 2] != 2'b11) ?
                               pwdata[LSC_BYP_LSB +: 2] : ctrl_reg[LSC_BYP_LSB +: 2];
  wire logic [9:0] ctrl_next = wr_ctrl_w ?
                               {pwdata[LSC_HOLD_BIT], pwdata[LSC_SLIP_BIT], byp_new_w, mode_new_w, factor_new_w} :
                               ctrl_reg;

  // ****************************************
  // Configuration decode
  // ****************************************
  wire logic [3:0] factor_w = ctrl_reg[LSC_FACTOR_LSB +: 4];
  wire lsc_mode_t mode_w = lsc_mode_t'(ctrl_reg[LSC_MODE_LSB +: 2]);
  wire lsc_byp_t byp_w = lsc_byp_t'(ctrl_reg[LSC_BYP_LSB +: 2]);
  wire logic slip_req_w = ctrl_reg[LSC_SLIP_BIT];
  wire logic hold_w = ctrl_reg[LSC_HOLD_BIT];
  wire logic [3:0] eff_w = lsc_eff_factor(byp_w, factor_w);
  wire logic [9:0] mask_w = lsc_mask(eff_w);
  wire logic serdes_on_w = (byp_w == LSC_BYP_NONE);
  // R11 selector only steers data in aligned modes
  wire logic dpa_on_w = serdes_on_w && (mode_w == LSC_DPA);
  wire logic cdr_on_w = serdes_on_w && (mode_w == LSC_SOFT_CDR);

  // ****************************************
  // Pin sample synchroniser
  // ****************************************
  logic [7:0] samp1_reg;
  logic [7:0] samp2_reg;
  logic [7:0] samp3_reg;
  logic [7:0] samp_reg;
  wire logic [7:0] agree_w = ~(samp2_reg ^ samp3_reg);
  wire logic [7:0] samp_next = (agree_w & samp3_reg) | (~agree_w & samp_reg);

  // ****************************************
  // Phase selector
  // ****************************************
  lsc_dpa_if dpa ();
  assign dpa.samples = samp_reg;
  assign dpa.hold = hold_w;
  assign dpa.rst = dpa_rst_reg;

  lsc_phase_sel u_phase_sel (
    .pclk(pclk),
    .presetn(presetn),
    .dpa(dpa.sel)
  );

  // R7 selected phase sample
  // R21 phase zero is the channel clock rising edge
  wire logic sel_bit_w = (dpa_on_w || cdr_on_w) ? samp_reg[dpa.phase] : samp_reg[0];

  // ****************************************
  // Synchroniser FIFO
  // ****************************************
  logic fifo_mem_reg [FIFO_DEPTH];
  logic [2:0] wptr_reg;
  logic [2:0] rptr_reg;
  logic [2:0] fill_reg;
  logic primed_reg;

  // R13 clear on first lock or request
  // R15 held clear when bypassed
  wire logic fifo_clr_w = fifo_rst_reg || dpa.first_lock || !dpa_on_w;
  wire logic [2:0] wptr_next = (wptr_reg == 3'(FIFO_DEPTH - 1)) ? 3'h0 : wptr_reg + 3'h1;
  wire logic [2:0] rptr_next = (rptr_reg == 3'(FIFO_DEPTH - 1)) ? 3'h0 : rptr_reg + 3'h1;
  // R12 fixed depth, phase offset only
  wire logic fifo_out_w = fifo_mem_reg[rptr_reg];
  wire logic rx_bit_w = dpa_on_w ? fifo_out_w : sel_bit_w;

  // ****************************************
  // Bit slip and deserializer
  // ****************************************
  logic [3:0] rx_cnt_reg;
  logic [9:0] rx_sh_reg;
  logic [9:0] rx_word_reg;
  logic rx_valid_reg;
  logic slip_prev_reg;
  logic [3:0] slip_cnt_reg;
  logic [3:0] max_cnt_reg;
  logic slip_max_reg;
  logic [2:0] settle_reg;
  logic divclk_reg;
  logic locked_reg;

  // R22 no slip in bypass
  wire logic slip_edge_w = slip_req_w && !slip_prev_reg && serdes_on_w;
  wire logic rx_wrap_w = (rx_cnt_reg >= eff_w - 4'h1);
  // R16 counter pauses one bit
  wire logic [3:0] rx_cnt_next = slip_edge_w ? rx_cnt_reg : (rx_wrap_w ? 4'h0 : rx_cnt_reg + 4'h1);
  wire logic rx_load_w = !slip_edge_w && rx_wrap_w;
  // R6 shift chain into load register
  wire logic [9:0] rx_sh_next = {rx_sh_reg[8:0], rx_bit_w};
  // R19 rollover at factor
  wire logic slip_roll_w = slip_edge_w && (slip_cnt_reg >= eff_w - 4'h1);
  wire logic [3:0] slip_cnt_next = slip_roll_w ? 4'h0 : (slip_edge_w ? slip_cnt_reg + 4'h1 : slip_cnt_reg);
  wire logic [3:0] max_cnt_next = slip_roll_w ? eff_w : ((max_cnt_reg != 4'h0) ? max_cnt_reg - 4'h1 : 4'h0);
  // R18 wait four words after slip
  wire logic [2:0] settle_next = slip_edge_w ? LSC_SLIP_SETTLE :
                                 ((rx_load_w && settle_reg != 3'h0) ? settle_reg - 3'h1 : settle_reg);
  // R10 data trusted only once trained
  wire logic rx_trust_w = (settle_next == 3'h0) &&
                          (!dpa_on_w || (primed_reg && dpa.locked)) && (!cdr_on_w || dpa.locked);
  // R23 divided clock high for first half of word
  wire logic divclk_next = cdr_on_w && ({rx_cnt_next, 1'b0} < {1'b0, eff_w});

  // ****************************************
  // Serializer
  // ****************************************
  logic [3:0] tx_cnt_reg;
  logic [9:0] tx_hold_reg;
  logic tx_serial_reg;
  logic tx_take_reg;

  // R24 one load per word period
  wire logic tx_load_w = (tx_cnt_reg == 4'h0);
  wire logic [3:0] tx_cnt_next = (tx_cnt_reg >= eff_w - 4'h1) ? 4'h0 : tx_cnt_reg + 4'h1;
  // R2 most significant bit leaves first
  wire logic [3:0] tx_idx_w = eff_w - 4'h1 - tx_cnt_reg;
  // R1 word captured into load register
  // R3 factor one or two in bypass
  wire logic [9:0] tx_src_w = tx_load_w ? (tx_word & mask_w) : tx_hold_reg;
  wire logic tx_bit_w = (tx_idx_w < 4'hA) ? tx_src_w[tx_idx_w] : 1'b0;

  // ****************************************
  // Status and read data
  // ****************************************
  wire logic [31:0] stat_w = {20'h00000, slip_cnt_reg, 1'b0, dpa.phase, 1'b0,
                              rx_valid_reg, primed_reg, dpa.locked};
  wire logic [31:0] rd_data_w = sel_ctrl_w ? {22'h00000, ctrl_reg} : (sel_stat_w ? stat_w : 32'h00000000);

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= LSC_CTRL_RST;
      dpa_rst_reg <= 1'b0;
      fifo_rst_reg <= 1'b0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else begin
      ctrl_reg <= ctrl_next;
      dpa_rst_reg <= wr_cmd_w && pwdata[LSC_DPA_RST_BIT];
      fifo_rst_reg <= wr_cmd_w && pwdata[LSC_FIFO_RST_BIT];
      pready_reg <= setup_w;
      pslverr_reg <= setup_w && !mapped_w;
      prdata_reg <= (setup_w && !pwrite) ? rd_data_w : 32'h00000000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      samp1_reg <= 8'h00;
      samp2_reg <= 8'h00;
      samp3_reg <= 8'h00;
      samp_reg <= 8'h00;
    end else begin
      samp1_reg <= rx_samples;
      samp2_reg <= samp1_reg;
      samp3_reg <= samp2_reg;
      samp_reg <= samp_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr_reg <= 3'h0;
      rptr_reg <= 3'h0;
      fill_reg <= 3'h0;
      primed_reg <= 1'b0;
    end else if (fifo_clr_w) begin
      wptr_reg <= 3'h0;
      rptr_reg <= 3'h0;
      fill_reg <= 3'h0;
      primed_reg <= 1'b0;
    end else begin
      wptr_reg <= wptr_next;
      if (primed_reg) begin
        rptr_reg <= rptr_next;
      end else begin
        fill_reg <= fill_reg + 3'h1;
        primed_reg <= (fill_reg == LSC_FIFO_PRIME - 3'h1);
      end
    end
  end

  // The storage needs no reset: reads wait for priming after every clear.
  always_ff @(posedge pclk) begin
    fifo_mem_reg[wptr_reg] <= sel_bit_w;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_cnt_reg <= 4'h0;
      rx_sh_reg <= 10'h000;
      slip_prev_reg <= 1'b0;
      slip_cnt_reg <= 4'h0;
      max_cnt_reg <= 4'h0;
      settle_reg <= 3'h0;
    end else begin
      rx_cnt_reg <= rx_cnt_next;
      rx_sh_reg <= rx_sh_next;
      slip_prev_reg <= slip_req_w;
      slip_cnt_reg <= slip_cnt_next;
      max_cnt_reg <= max_cnt_next;
      settle_reg <= settle_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_word_reg <= 10'h000;
      rx_valid_reg <= 1'b0;
      slip_max_reg <= 1'b0;
      divclk_reg <= 1'b0;
      locked_reg <= 1'b0;
    end else begin
      // R20 bypass shares the load path at factor one or two
      // R25 word changes only at the boundary
      if (rx_load_w) begin
        rx_word_reg <= rx_sh_next & mask_w;
        rx_valid_reg <= rx_trust_w;
      end
      // R19 pulse lasts one word period
      slip_max_reg <= (max_cnt_next != 4'h0);
      divclk_reg <= divclk_next;
      // R9 lock status, one cycle behind the selector
      locked_reg <= dpa.locked;
    end
  end

  // R4 bypass output still leaves a register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_cnt_reg <= 4'h0;
      tx_hold_reg <= 10'h000;
      tx_serial_reg <= 1'b0;
      tx_take_reg <= 1'b0;
    end else begin
      tx_cnt_reg <= tx_cnt_next;
      tx_hold_reg <= tx_src_w;
      tx_serial_reg <= tx_bit_w;
      tx_take_reg <= tx_load_w;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign prdata = prdata_reg;
  assign tx_take = tx_take_reg;
  assign tx_serial = tx_serial_reg;
  assign rx_word = rx_word_reg;
  assign rx_word_valid = rx_valid_reg;
  assign rx_locked = locked_reg;
  assign rx_slip_max = slip_max_reg;
  assign rx_divclk = divclk_reg;

endmodule
`default_nettype wire

// *** tb/lsc_serdes_channel_assertions.sv ***
// Port checker for the serial channel.
`timescale 1ns/10ps
`default_nettype none
module lsc_chk
  import lsc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Register bus
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // Channel
  input wire logic tx_take,
  input wire logic [9:0] rx_word,
  input wire logic rx_locked,
  input wire logic rx_slip_max,
  input wire logic rx_divclk
);
  // ****************
  // Shadow state
  // ****************
  // Periods are judged only long after a setup change, so words in flight across it pass.
  logic [3:0] fac_reg;
  logic [1:0] mode_reg;
  logic [1:0] byp_reg;
  logic [4:0] age_reg;
  logic [3:0] gap_reg;
  logic [3:0] wgap_reg;
  logic [3:0] run_reg;
  wire ctl_wr = psel && penable && pready && pwrite && paddr == LSC_CTRL_OFS;
  wire [3:0] nf = pwdata[3:0];
  wire [7:0] cfg_now = {byp_reg, mode_reg, fac_reg};
  wire [3:0] eff = byp_reg == 2'h1 ? 4'h1 : (byp_reg == 2'h2 ? 4'h2 : fac_reg);
  wire calm = age_reg == 5'h1F;
  wire mapped = paddr inside {LSC_CTRL_OFS, LSC_STAT_OFS, LSC_CMD_OFS};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fac_reg <= LSC_CTRL_RST[3:0];
      mode_reg <= LSC_CTRL_RST[5:4];
      byp_reg <= LSC_CTRL_RST[7:6];
      age_reg <= 5'h00;
      gap_reg <= 4'h0;
      wgap_reg <= 4'h0;
      run_reg <= 4'h0;
    end else begin
      if (ctl_wr && nf >= LSC_MIN_FACTOR && nf <= LSC_TOP_FACTOR) begin
        fac_reg <= nf;
      end
      if (ctl_wr && pwdata[5:4] != 2'h3) begin
        mode_reg <= pwdata[5:4];
      end
      if (ctl_wr && pwdata[7:6] != 2'h3) begin
        byp_reg <= pwdata[7:6];
      end
      age_reg <= (ctl_wr && pwdata[7:0] != cfg_now) ? 5'h00 : age_reg + {4'h0, !calm};
      gap_reg <= tx_take ? 4'h0 : gap_reg + {3'h0, gap_reg != 4'hF};
      wgap_reg <= $changed(rx_word) ? 4'h0 : wgap_reg + {3'h0, wgap_reg != 4'hF};
      run_reg <= rx_slip_max ? run_reg + 4'h1 : 4'h0;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence setup_phase;
    psel && !penable;
  endsequence
  sequence answer_once;
    pready ##1 !pready;
  endsequence
  sequence cmd_dpa_reset;
    psel && penable && pready && pwrite && paddr == LSC_CMD_OFS && pwdata[LSC_DPA_RST_BIT];
  endsequence
  chk_ready_timing: assert property (setup_phase |=> answer_once)
    else $error("pready timing wrong");
  chk_ready_cause: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  chk_map_error: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr wrong");
  chk_idle_quiet: assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("bus not quiet");
  chk_cmd_zero: assert property (pready && !pwrite && paddr == LSC_CMD_OFS |-> prdata == 32'h0)
    else $error("command reads nonzero");
  chk_ctrl_readback: assert property (pready && !pwrite && paddr == LSC_CTRL_OFS |-> prdata[7:0] == cfg_now)
    else $error("control readback wrong");
  chk_take_period: assert property (tx_take && calm |-> gap_reg == eff - 4'h1)
    else $error("word take period wrong");
  chk_word_hold: assert property ($changed(rx_word) && calm |-> wgap_reg >= eff - 4'h1)
    else $error("received word changed early");
  chk_slip_max_len: assert property ($fell(rx_slip_max) && calm |-> run_reg == eff)
    else $error("rollover pulse wrong");
  chk_lock_drop: assert property (cmd_dpa_reset |-> ##[1:4] !rx_locked)
    else $error("lock kept after phase reset");
  chk_divclk_mode: assert property (mode_reg != LSC_SOFT_CDR && calm |-> !rx_divclk)
    else $error("divided clock outside mode");
endmodule
bind lsc_serdes_channel lsc_chk u_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .tx_take(tx_take), .rx_word(rx_word), .rx_locked(rx_locked), .rx_slip_max(rx_slip_max), .rx_divclk(rx_divclk));
`default_nettype wire

// *** tb/lsc_link_peer.sv ***
// Far end of the link: a remote sender whose bit edges fall at a set phase.
`timescale 1ns/10ps
`default_nettype none
module lsc_link_peer (
  // Clock
  input wire logic pclk,
  // Serial stream and edge position
  input wire logic bit_in,
  input wire logic [2:0] skew,
  // Phase samples
  output logic [7:0] samples
);
  logic prev_reg;
  logic cur_reg;
  always_ff @(posedge pclk) begin
    prev_reg <= cur_reg;
    cur_reg <= bit_in;
  end
  // edges show eye.
  // Early phases still see the old bit, so every data edge reveals where the eye sits.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      samples[i] = (i < skew) ? prev_reg : cur_reg;
    end
  end
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench: the channel looped back through the link model.
`timescale 1ns/10ps
`default_nettype none
module testbench
  import lsc_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [9:0] tx_word = 10'h000;
  logic [2:0] skew = 3'h2;
  logic pready, pslverr, tx_take, tx_serial, rx_word_valid, rx_locked, rx_slip_max, rx_divclk, rerr;
  logic [31:0] prdata, rdat;
  logic [9:0] rx_word;
  logic [7:0] rx_samples;
  logic max_seen = 1'b0;
  int failures = 0;
  int check_count = 0;
  logic [3:0] tx_fac [4] = '{4'h3, 4'hA, 4'h4, 4'h4};
  logic [1:0] tx_byp [4] = '{2'h0, 2'h0, 2'h1, 2'h2};
  logic [3:0] tx_eff [4] = '{4'h3, 4'hA, 4'h1, 4'h2};
  logic [9:0] tx_val [4] = '{10'h3F6, 10'h2C9, 10'h3FD, 10'h001};
  always #4 pclk = ~pclk;
  always @(posedge pclk) if (rx_slip_max === 1'b1) max_seen <= 1'b1;
  lsc_serdes_channel DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .tx_word(tx_word), .tx_take(tx_take), .tx_serial(tx_serial), .rx_samples(rx_samples),
    .rx_word(rx_word), .rx_word_valid(rx_word_valid), .rx_locked(rx_locked),
    .rx_slip_max(rx_slip_max), .rx_divclk(rx_divclk));
  lsc_link_peer peer (.pclk(pclk), .bit_in(tx_serial), .skew(skew), .samples(rx_samples));
  // ****************
  // Tasks
  // ****************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] cfg(input logic [3:0] f, input logic [1:0] m, input logic [1:0] b,
                                      input logic s, input logic h);
    return {22'h0, h, s, b, m, f};
  endfunction
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    check(n < 20, 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_high(ref logic s, input int lim);
    int n;
    n = 0;
    while (s !== 1'b1 && n < lim) begin
      @(posedge pclk);
      n++;
    end
    check(n < lim, 1'b1);
  endtask
  task automatic tx_check(input logic [9:0] w, input logic [3:0] e);
    logic [9:0] got;
    got = 10'h000;
    tx_word <= w;
    repeat (2) begin
      @(posedge pclk);
      wait_high(tx_take, 40);
    end
    for (int k = 0; k < e; k++) begin
      got = {got[8:0], tx_serial};
      @(posedge pclk);
    end
    check(got, w & 10'((11'h001 << e) - 11'h001));
    check(tx_take, 1'b1);
  endtask
  task automatic print_verdict();
    $display("Checks: %0d, mismatches: %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ****************
  // Tests
  // ****************
  initial begin
    #200000;
    failures++;
    $display("Error at %0t: watchdog expired", $time);
    print_verdict();
  end
  initial begin
    int m, n;
    logic [2:0] p1;
    m = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, LSC_CTRL_OFS, 32'h0);
    check(rdat, {22'h0, LSC_CTRL_RST});
    apb(1'b1, LSC_CMD_OFS, 32'h0);
    apb(1'b0, LSC_CMD_OFS, 32'h0);
    check(rdat, 32'h0);
    apb(1'b0, 8'h0C, 32'h0);
    check(rerr, 1'b1);
    apb(1'b1, LSC_CTRL_OFS, cfg(4'h2, 2'h3, 2'h3, 1'b0, 1'b0));
    apb(1'b0, LSC_CTRL_OFS, 32'h0);
    check(rdat, {22'h0, LSC_CTRL_RST});
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, LSC_CTRL_OFS, cfg(tx_fac[i], 2'h1, tx_byp[i], 1'b0, 1'b0));
      tx_check(tx_val[i], tx_eff[i]);
    end
    apb(1'b1, LSC_CTRL_OFS, cfg(4'h4, 2'h1, 2'h2, 1'b1, 1'b0));
    apb(1'b0, LSC_STAT_OFS, 32'h0);
    check(rdat[11:8], 4'h0);
    apb(1'b1, LSC_CTRL_OFS, cfg(4'h4, 2'h1, 2'h0, 1'b0, 1'b0));
    tx_word <= 10'h00C;
    apb(1'b1, LSC_CMD_OFS, 32'h1);
    repeat (3) @(posedge pclk);
    check(rx_locked, 1'b0);
    wait_high(rx_locked, 400);
    apb(1'b0, LSC_STAT_OFS, 32'h0);
    check(rdat[LSC_LOCKED_BIT], 1'b1);
    p1 = rdat[6:4];
    apb(1'b1, LSC_CTRL_OFS, cfg(4'h4, 2'h1, 2'h0, 1'b0, 1'b1));
    skew <= 3'h6;
    repeat (60) @(posedge pclk);
    apb(1'b0, LSC_STAT_OFS, 32'h0);
    check(rdat[6:4], p1);
    apb(1'b1, LSC_CTRL_OFS, cfg(4'h4, 2'h1, 2'h0, 1'b0, 1'b0));
    repeat (60) @(posedge pclk);
    apb(1'b0, LSC_STAT_OFS, 32'h0);
    check(rdat[6:4] != p1, 1'b1);
    apb(1'b1, LSC_CMD_OFS, 32'h2);
    wait_high(rx_word_valid, 400);
    for (int k = 1; k <= 4; k++) begin
      m += (rx_word[3:0] === 4'hC);
      apb(1'b1, LSC_CTRL_OFS, cfg(4'h4, 2'h1, 2'h0, 1'b1, 1'b0));
      n = 0;
      while (rx_word_valid !== 1'b0 && n < 20) begin
        @(posedge pclk);
        n++;
      end
      while (rx_word_valid !== 1'b1 && n < 40) begin
        @(posedge pclk);
        n++;
      end
      check(n >= 12 && n <= 18, 1'b1);
      apb(1'b1, LSC_CTRL_OFS, cfg(4'h4, 2'h1, 2'h0, 1'b0, 1'b0));
      apb(1'b0, LSC_STAT_OFS, 32'h0);
      check(rdat[11:8], 4'(k % 4));
    end
    check(m, 1);
    check(max_seen, 1'b1);
    apb(1'b1, LSC_CTRL_OFS, cfg(4'h4, 2'h2, 2'h0, 1'b0, 1'b0));
    wait_high(rx_divclk, 200);
    apb(1'b1, LSC_CTRL_OFS, cfg(4'h4, 2'h0, 2'h0, 1'b0, 1'b0));
    repeat (4) @(posedge pclk);
    wait_high(rx_word_valid, 200);
    print_verdict();
  end
endmodule
`default_nettype wire
